// File: design/stc_timer.sv
// Standard timer control, compare and counter core with APB registers
//
// Notes on behaviour
// - Clock select picks count source
// - Run low stops counter, holds value
// - Run rising edge zeroes counter
// - Run rise loads output initial level, except in capture and timer/counter modes
// - Mode field selects operating mode
// - Compare mode: pin action on match
// - PWM mode: forced levels, PWM, pulse
// - Capture mode: edge select or off
// - Equal requested level shows no change
// - Initial level bit meaning per mode
// - Polarity bit inverts output pin
// - Swap bit exchanges period and duty
// - Clear source: A match or P/overflow
// - Overflow clear only when P zero
// - Clear source ignored in other modes
// - Counter readable as low/high byte
// - Compare A is full-width read/write
// - Wide P compares counter upper byte
// - A low byte buffered until high write
// - High read buffers low byte
// - Pause freezes counter while powered
// - Narrow P compares counter bits 9:7
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
module stc_timer #(
   parameter bit VARIANT_16 = 1'b1 // 1: 16-bit counter, 0: 10-bit
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Prescaler source ticks, same clock domain
   input wire logic high_speed_clock_tick,
   input wire logic sub_clock_tick,
   // Pins
   input wire logic external_count_clock_pin,
   input wire logic capture_input_pin,
   output logic timer_output_pin,
   output logic timer_output_pin_oe,
   // Events to mode and interrupt logic
   output logic match_a_evt,
   output logic match_p_evt,
   output logic counter_clear_evt,
   output logic capture_evt
);
   // ==========================================
   // Registers
   logic [7:0] ctrl0_r; // Pause, clock select, run, narrow P
   logic [7:0] ctrl1_r; // Mode, pin function, level, polarity
   logic [7:0] cmpp_r; // Wide compare P
   logic [15:0] cmpa_r; // Compare A
   logic [7:0] buf_r; // Shared byte holding buffer
   logic [15:0] cnt_r; // Counter
   logic [5:0] pre_r; // Prescaler
   logic run_d_r; // Previous run bit
   logic out_lvl_r; // Output level before polarity
   logic ext_s1_r, ext_s2_r, ext_s3_r; // External clock sync
   logic cap_s1_r, cap_s2_r, cap_s3_r; // Capture pin sync
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic pin_r, pin_oe_r;
   logic a_evt_r, p_evt_r, clr_evt_r, cap_evt_r;

   // ==========================================
   // Field decode
   wire pause = ctrl0_r[stc_pkg::C0_PAUSE];
   wire [2:0] cksel = ctrl0_r[stc_pkg::C0_CKSEL_LO +: 3];
   wire run = ctrl0_r[stc_pkg::C0_RUN];
   wire [1:0] mode = ctrl1_r[stc_pkg::C1_MODE_LO +: 2];
   wire [1:0] iosel = ctrl1_r[stc_pkg::C1_IO_LO +: 2];
   wire init_lvl = ctrl1_r[stc_pkg::C1_INIT];
   wire pol = ctrl1_r[stc_pkg::C1_POL];
   wire swap = ctrl1_r[stc_pkg::C1_SWAP];
   wire clr_src = ctrl1_r[stc_pkg::C1_CLRSRC];
   wire [15:0] cmask = VARIANT_16 ? stc_pkg::MASK_16 : stc_pkg::MASK_10;

   // ==========================================
   // APB decode
   wire setup = psel & ~penable;
   wire acc = psel & penable & pready_r;
   wire wr_acc = acc & pwrite & ~pslverr_r;
   wire rd_acc = acc & ~pwrite & ~pslverr_r;
   wire hit_c0 = paddr == stc_pkg::OFS_CTRL0;
   wire hit_c1 = paddr == stc_pkg::OFS_CTRL1;
   wire hit_dl = paddr == stc_pkg::OFS_CNT_LO;
   wire hit_dh = paddr == stc_pkg::OFS_CNT_HI;
   wire hit_al = paddr == stc_pkg::OFS_CMPA_LO;
   wire hit_ah = paddr == stc_pkg::OFS_CMPA_HI;
   wire hit_rp = (paddr == stc_pkg::OFS_CMPP) & VARIANT_16;
   wire mapped = hit_c0 | hit_c1 | hit_dl | hit_dh | hit_al | hit_ah | hit_rp;
   // Narrow variant keeps P in control zero, wide reads those bits as zero
   wire [7:0] c0_rd = VARIANT_16 ? {ctrl0_r[7:3], 3'h0} : ctrl0_r;
   wire [15:0] cnt_v = cnt_r & cmask;
   wire [15:0] cmpa_v = cmpa_r & cmask;
   // Low byte reads come from the buffer
   wire [7:0] rd_byte = hit_c0 ? c0_rd :
                        hit_c1 ? ctrl1_r :
                        (hit_dl | hit_al) ? buf_r :
                        hit_dh ? cnt_v[15:8] :
                        hit_ah ? cmpa_v[15:8] :
                        hit_rp ? cmpp_r : 8'h00;

   // ==========================================
   // Pin synchronisers and edges
   // Edge taken only after two flops
   wire ext_rise = ext_s2_r & ~ext_s3_r;
   wire ext_fall = ~ext_s2_r & ext_s3_r;
   wire cap_rise = cap_s2_r & ~cap_s3_r;
   wire cap_fall = ~cap_s2_r & cap_s3_r;

   // ==========================================
   // Count tick selection
   // Eight clock source codes
   function automatic logic tick_of(input logic [2:0] sel, input logic [5:0] pre,
                                    input logic hi, input logic sb,
                                    input logic er, input logic ef);
      logic t;
      t = 1'b0;
      unique case (sel)
         stc_pkg::CK_SYS4: t = pre[1:0] == stc_pkg::PRE_SYS4[1:0];
         stc_pkg::CK_SYS: t = 1'b1;
         stc_pkg::CK_HI16: t = hi & (pre[3:0] == stc_pkg::PRE_HI16[3:0]);
         stc_pkg::CK_HI64: t = hi & (pre == stc_pkg::PRE_HI64);
         stc_pkg::CK_SUB_A, stc_pkg::CK_SUB_B: t = sb;
         stc_pkg::CK_EXT_R: t = er;
         stc_pkg::CK_EXT_F: t = ef;
      endcase
      return t;
   endfunction

   wire tick = tick_of(cksel, pre_r, high_speed_clock_tick, sub_clock_tick,
                       ext_rise, ext_fall);
   // Prescaler advances on its own source only
   wire pre_step = (cksel == stc_pkg::CK_SYS4) |
                   (((cksel == stc_pkg::CK_HI16) | (cksel == stc_pkg::CK_HI64)) &
                    high_speed_clock_tick);
   wire run_rise = run & ~run_d_r;
   // Stopped or paused counter never advances
   wire count_en = run & ~run_d_r ? 1'b0 : (run & ~pause & tick);

   // ==========================================
   // Comparators
   wire [15:0] cnt_nxt = 16'(cnt_r + 16'h0001) & cmask;
   // A compared on all counter bits, zero never matches
   wire a_hit = count_en & (cnt_nxt == cmpa_v) & (cmpa_v != 16'h0000);
   // Wide P on bits 15:8, zero means wrap
   wire p_hit16 = (cnt_nxt[15:8] == cmpp_r) & (cnt_nxt[7:0] == 8'h00);
   wire p_hit10 = (cnt_nxt[9:7] == ctrl0_r[2:0]) & (cnt_nxt[6:0] == 7'h00);
   wire p_hit = count_en & (VARIANT_16 ? p_hit16 : p_hit10);
   wire cmp_like = (mode == stc_pkg::MODE_CMP) | (mode == stc_pkg::MODE_TC);
   wire clr_by_a = cmp_like ? clr_src : ((mode == stc_pkg::MODE_PWM) & swap);
   wire clr_hit = clr_by_a ? a_hit : p_hit;
   // P flag suppressed when A clears in compare-like modes
   wire p_flag = p_hit & ~(cmp_like & clr_src);

   // ==========================================
   // Duty for PWM
   // Swap picks which register is duty
   wire [16:0] p_span16 = (cmpp_r == 8'h00) ? 17'h10000 : {1'b0, cmpp_r, 8'h00};
   wire [16:0] p_span10 = (ctrl0_r[2:0] == 3'h0) ? 17'h00400 :
                          {7'h00, ctrl0_r[2:0], 7'h00};
   wire [16:0] p_span = VARIANT_16 ? p_span16 : p_span10;
   wire [16:0] duty = swap ? p_span : {1'b0, cmpa_v};
   wire pwm_act = {1'b0, cnt_v} < duty;

   // ==========================================
   // Output level next value
   logic lvl_nxt;
   always_comb begin
      lvl_nxt = out_lvl_r;
      if (run_rise) begin
         if (mode != stc_pkg::MODE_CAP && mode != stc_pkg::MODE_TC) begin
            lvl_nxt = init_lvl;
         end
      end else if (mode == stc_pkg::MODE_CMP) begin
         // Match action; same level shows no change
         if (a_hit) begin
            unique case (iosel)
               stc_pkg::IO_0: lvl_nxt = out_lvl_r;
               stc_pkg::IO_1: lvl_nxt = 1'b0;
               stc_pkg::IO_2: lvl_nxt = 1'b1;
               stc_pkg::IO_3: lvl_nxt = ~out_lvl_r;
            endcase
         end
      end else if (mode == stc_pkg::MODE_PWM && run) begin
         // Forced inactive, forced active, PWM, single pulse
         unique case (iosel)
            stc_pkg::IO_0: lvl_nxt = ~init_lvl;
            stc_pkg::IO_1: lvl_nxt = init_lvl;
            stc_pkg::IO_2: lvl_nxt = pwm_act ? init_lvl : ~init_lvl;
            stc_pkg::IO_3: lvl_nxt = a_hit ? ~init_lvl : out_lvl_r;
         endcase
      end
   end

   // Capture edge selection, active only while running
   wire cap_edge = (iosel == stc_pkg::IO_0) ? cap_rise :
                   (iosel == stc_pkg::IO_1) ? cap_fall :
                   (iosel == stc_pkg::IO_2) ? (cap_rise | cap_fall) : 1'b0;
   wire cap_hit = run & (mode == stc_pkg::MODE_CAP) & cap_edge;

   // ==========================================
   // Synchronisers; first stage feeds only the second
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
         cap_s1_r <= 1'b0;
         cap_s2_r <= 1'b0;
         cap_s3_r <= 1'b0;
      end else begin
         ext_s1_r <= external_count_clock_pin;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
         cap_s1_r <= capture_input_pin;
         cap_s2_r <= cap_s1_r;
         cap_s3_r <= cap_s2_r;
      end
   end

   // ==========================================
   // Software registers and byte buffer
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl0_r <= stc_pkg::REG_RESET;
         ctrl1_r <= stc_pkg::REG_RESET;
         cmpp_r <= stc_pkg::REG_RESET;
         cmpa_r <= 16'h0000;
         buf_r <= stc_pkg::REG_RESET;
      end else begin
         // Control one holds the mode field
         if (wr_acc & hit_c0) begin
            ctrl0_r <= pwdata[7:0];
         end
         if (wr_acc & hit_c1) begin
            ctrl1_r <= pwdata[7:0];
         end
         if (wr_acc & hit_rp) begin
            cmpp_r <= pwdata[7:0];
         end
         // Low write only buffers; high write commits both
         if (wr_acc & hit_al) begin
            buf_r <= pwdata[7:0];
         end else if (wr_acc & hit_ah) begin
            cmpa_r <= {pwdata[7:0], buf_r} & cmask;
         end else if (setup & ~pwrite & hit_dh) begin
            // Snapshot taken with the high byte, so a running count never tears
            buf_r <= cnt_v[7:0];
         end else if (rd_acc & hit_ah) begin
            buf_r <= cmpa_v[7:0];
         end
      end
   end

   // ==========================================
   // Counter, prescaler and run edge
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= 16'h0000;
         pre_r <= 6'h00;
         run_d_r <= 1'b0;
      end else begin
         run_d_r <= run;
         // Prescaler held in reset while off to save power
         pre_r <= !run ? 6'h00 : (pre_step & ~pause ? 6'(pre_r + 6'h01) : pre_r);
         if (run_rise) begin
            cnt_r <= 16'h0000;
         end else if (count_en) begin
            cnt_r <= clr_hit ? 16'h0000 : cnt_nxt;
         end
      end
   end

   // ==========================================
   // Output level, pin and events
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_lvl_r <= 1'b0;
         pin_r <= 1'b0;
         pin_oe_r <= 1'b0;
         a_evt_r <= 1'b0;
         p_evt_r <= 1'b0;
         clr_evt_r <= 1'b0;
         cap_evt_r <= 1'b0;
      end else begin
         out_lvl_r <= lvl_nxt;
         // Polarity applies except in timer/counter mode
         pin_r <= (mode == stc_pkg::MODE_TC) ? 1'b0 : (out_lvl_r ^ pol);
         pin_oe_r <= run & (mode != stc_pkg::MODE_TC) & (mode != stc_pkg::MODE_CAP);
         a_evt_r <= a_hit;
         p_evt_r <= p_flag;
         clr_evt_r <= count_en & clr_hit;
         cap_evt_r <= cap_hit;
      end
   end

   // ==========================================
   // APB answer, one wait-free access phase
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup & ~mapped;
         if (setup & ~pwrite) begin
            prdata_r <= {24'h00_0000, rd_byte};
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign timer_output_pin = pin_r;
   assign timer_output_pin_oe = pin_oe_r;
   assign match_a_evt = a_evt_r;
   assign match_p_evt = p_evt_r;
   assign counter_clear_evt = clr_evt_r;
   assign capture_evt = cap_evt_r;

   // ==========================================
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   a_run_rise_zero: assert property (run_rise |=> cnt_r == 16'h0000)
      else $error("counter not zero after run start");
   a_stop_holds: assert property (!run |=> $stable(cnt_r))
      else $error("counter moved while stopped");
   a_pause_holds: assert property (run & run_d_r & pause |=> $stable(cnt_r))
      else $error("counter moved while paused");
   a_init_level: assert property (run_rise & (mode == stc_pkg::MODE_CMP)
      |=> out_lvl_r == $past(init_lvl))
      else $error("initial level not loaded");
   a_match_event: assert property (a_hit
      |=> match_a_evt ##1 (!match_a_evt || $past(a_hit)))
      else $error("A match event missing");
   a_clear_on_a: assert property (a_hit & cmp_like & clr_src |=> cnt_r == 16'h0000)
      else $error("A match did not clear counter");
   a_toggle_cmp: assert property (a_hit & ~run_rise & (mode == stc_pkg::MODE_CMP)
      & (iosel == stc_pkg::IO_3) |=> out_lvl_r != $past(out_lvl_r))
      else $error("toggle did not happen");
   a_pin_polar: assert property ((mode != stc_pkg::MODE_TC) & $stable(mode)
      |=> timer_output_pin == ($past(out_lvl_r) ^ $past(pol)))
      else $error("pin polarity wrong");
   a_ah_commit: assert property (wr_acc & hit_ah
      |=> cmpa_r[7:0] == ($past(buf_r) & cmask[7:0]))
      else $error("buffered low byte not committed");
   a_apb_ready: assert property (setup |=> pready ##1 (!pready || $past(setup)))
      else $error("access phase not answered in one cycle");

   c_run_start: cover property (run_rise ##[1:20] count_en);
   c_p_match: cover property (match_p_evt);
   c_a_toggle: cover property (a_hit & (iosel == stc_pkg::IO_3));
   c_capture: cover property (capture_evt);
endmodule

// File: design/stc_pkg.sv
// Shared constants for the standard timer control block
package stc_pkg;
   // ==========================================
   // Register byte addresses on APB
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_CNT_LO = 8'h08;
   localparam logic [7:0] OFS_CNT_HI = 8'h0C;
   localparam logic [7:0] OFS_CMPA_LO = 8'h10;
   localparam logic [7:0] OFS_CMPA_HI = 8'h14;
   localparam logic [7:0] OFS_CMPP = 8'h18;
   // ==========================================
   // Control zero fields
   localparam int C0_PAUSE = 7;
   localparam int C0_CKSEL_LO = 4;
   localparam int C0_RUN = 3;
   // Control one fields
   localparam int C1_MODE_LO = 6;
   localparam int C1_IO_LO = 4;
   localparam int C1_INIT = 3;
   localparam int C1_POL = 2;
   localparam int C1_SWAP = 1;
   localparam int C1_CLRSRC = 0;
   localparam logic [7:0] REG_RESET = 8'h00;
   // ==========================================
   // Operating modes
   localparam logic [1:0] MODE_CMP = 2'h0;
   localparam logic [1:0] MODE_CAP = 2'h1;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_TC = 2'h3;
   // Pin function codes
   localparam logic [1:0] IO_0 = 2'h0;
   localparam logic [1:0] IO_1 = 2'h1;
   localparam logic [1:0] IO_2 = 2'h2;
   localparam logic [1:0] IO_3 = 2'h3;
   // Counter clock sources
   localparam logic [2:0] CK_SYS4 = 3'h0;
   localparam logic [2:0] CK_SYS = 3'h1;
   localparam logic [2:0] CK_HI16 = 3'h2;
   localparam logic [2:0] CK_HI64 = 3'h3;
   localparam logic [2:0] CK_SUB_A = 3'h4;
   localparam logic [2:0] CK_SUB_B = 3'h5;
   localparam logic [2:0] CK_EXT_R = 3'h6;
   localparam logic [2:0] CK_EXT_F = 3'h7;
   // Prescaler terminal counts
   localparam logic [5:0] PRE_SYS4 = 6'h03;
   localparam logic [5:0] PRE_HI16 = 6'h0F;
   localparam logic [5:0] PRE_HI64 = 6'h3F;
   // Counter masks for the two variants
   localparam logic [15:0] MASK_16 = 16'hFFFF;
   localparam logic [15:0] MASK_10 = 16'h03FF;
endpackage

// File: verif/stc_far_side.sv
// Far-side model: prescaler ticks, count clock pin and capture pin
`timescale 1ns/10ps
module stc_far_side (
   // Clock
   input wire logic core_clk,
   // Ticks and pins toward the timer
   output logic high_speed_clock_tick,
   output logic sub_clock_tick,
   output logic external_count_clock_pin,
   output logic capture_input_pin
);
   // Free-running divider for the tick sources
   logic [3:0] div_r = 4'h0;

   // ==========================================
   // Pins idle low between pulses
   initial begin
      high_speed_clock_tick = 1'b0;
      sub_clock_tick = 1'b0;
      external_count_clock_pin = 1'b0;
      capture_input_pin = 1'b0;
   end

   // ==========================================
   // High tick every 2nd cycle, sub tick every 4th
   always @(posedge core_clk) begin
      div_r <= div_r + 4'h1;
      high_speed_clock_tick <= div_r[0];
      sub_clock_tick <= (div_r[1:0] == 2'h3);
   end

   // ==========================================
   // Slow pulses: 4 cycles per level, so the synchroniser sees each edge
   task automatic ext_pulses(input int n);
      repeat (n) begin
         external_count_clock_pin <= 1'b1;
         repeat (4) @(posedge core_clk);
         external_count_clock_pin <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
   endtask

   // One capture pulse: one rising and one falling edge
   task automatic cap_pulse;
      capture_input_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      capture_input_pin <= 1'b0;
      repeat (8) @(posedge core_clk);
   endtask
endmodule

// File: verif/tb_standard_timer_control.sv
// Self-checking bench for the standard timer control block
`timescale 1ns/10ps
module tb_standard_timer_control;
   // ==========================================
   // Design-facing signals
   logic core_clk, rst_b, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, hs_tick, sub_tick, ext_pin, cap_pin;
   logic out_pin, out_oe, evt_a, evt_p, evt_clr, evt_cap;
   // Counters and expectation queue
   int bad_count = 0, n_compared = 0, n_a = 0, n_p = 0, n_clr = 0, n_cap = 0;
   int i, e, k, dv[6] = '{4, 1, 32, 128, 4, 4}, cap_exp[4] = '{1, 1, 2, 0};
   logic [7:0] fc[4] = '{8'h89, 8'h99, 8'hB9, 8'hB1};
   logic fp[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   logic [31:0] rnd = 32'hC39F;
   logic [15:0] a_m = 16'h0000;
   typedef struct {logic wr; logic [7:0] lo; logic [7:0] hi; logic err;} stc_note_t;
   stc_note_t notes[$];
   stc_note_t cur;

   initial core_clk = 1'b0;
   always #12.5 core_clk = ~core_clk;

   stc_timer #(.VARIANT_16(1'b1)) dut_u (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .high_speed_clock_tick(hs_tick),
      .sub_clock_tick(sub_tick), .external_count_clock_pin(ext_pin),
      .capture_input_pin(cap_pin), .timer_output_pin(out_pin), .timer_output_pin_oe(out_oe),
      .match_a_evt(evt_a), .match_p_evt(evt_p), .counter_clear_evt(evt_clr),
      .capture_evt(evt_cap));
   stc_far_side far_u (.core_clk(core_clk), .high_speed_clock_tick(hs_tick),
      .sub_clock_tick(sub_tick), .external_count_clock_pin(ext_pin),
      .capture_input_pin(cap_pin));

   // ==========================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Unknown fails too, since ok must be exactly 1
   task automatic check(input logic ok, input string what);
      n_compared++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("[ERR] %0t %s", $time, what);
      end
   endtask

   // One APB transfer; the expectation goes on the queue first
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] lo, input logic [7:0] hi, input logic err);
      int t;
      @(posedge core_clk);
      notes.push_back('{wr, lo, hi, err});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      t = 0;
      @(posedge core_clk);
      // Hold the request until pready is sampled high
      while (pready !== 1'b1 && t < 20) begin
         @(posedge core_clk);
         t++;
      end
      check(t < 20, "no pready");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 8'h00, 8'h00, 1'b0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      apb(1'b0, a, 8'h00, x, x, 1'b0);
   endtask

   // Counter through the high-then-low byte pair
   task automatic cnt_is(input logic [7:0] x);
      rd(stc_pkg::OFS_CNT_HI, 8'h00);
      rd(stc_pkg::OFS_CNT_LO, x);
   endtask

   // Stop, reconfigure, restart on external rising edges
   task automatic run(input logic [7:0] c1);
      wr(stc_pkg::OFS_CTRL0, 8'h60);
      wr(stc_pkg::OFS_CTRL1, c1);
      wr(stc_pkg::OFS_CTRL0, 8'h68);
      repeat (4) @(posedge core_clk);
   endtask

   task automatic pulse(input int n);
      far_u.ext_pulses(n);
      repeat (6) @(posedge core_clk);
   endtask

   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ==========================================
   // Response monitor: oldest note against each completed transfer
   always @(posedge core_clk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         cur = notes.pop_front();
         check(pslverr === cur.err, "response code");
         if (!cur.wr) begin
            check(prdata[31:8] === 24'h0 && prdata[7:0] >= cur.lo
                  && prdata[7:0] <= cur.hi, "read data");
         end
      end
   end

   // Event pulse counters
   always @(posedge core_clk) begin
      n_a += int'(evt_a === 1'b1);
      n_p += int'(evt_p === 1'b1);
      n_clr += int'(evt_clr === 1'b1);
      n_cap += int'(evt_cap === 1'b1);
   end

   // Watchdog: the full run needs well under 20000 cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      stop_test();
   end

   // ==========================================
   // Main sequence
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      // Reset values, unmapped place, read-only counter
      for (i = 0; i < 7; i++) rd(8'(4 * i), 8'h00);
      apb(1'b0, 8'h20, 8'h00, 8'h00, 8'h00, 1'b1);
      apb(1'b1, 8'h20, 8'h55, 8'h00, 8'h00, 1'b1);
      wr(stc_pkg::OFS_CNT_LO, 8'hFF);
      cnt_is(8'h00);
      wr(stc_pkg::OFS_CTRL0, 8'h77);
      rd(stc_pkg::OFS_CTRL0, 8'h70);
      // Random compare A pairs and control readback
      for (i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         wr(stc_pkg::OFS_CMPA_LO, rnd[7:0]);
         rd(stc_pkg::OFS_CMPA_HI, a_m[15:8]);
         rd(stc_pkg::OFS_CMPA_LO, a_m[7:0]);
         wr(stc_pkg::OFS_CMPA_LO, rnd[7:0]);
         wr(stc_pkg::OFS_CMPA_HI, rnd[15:8]);
         a_m = rnd[15:0];
         rd(stc_pkg::OFS_CMPA_HI, a_m[15:8]);
         rd(stc_pkg::OFS_CMPA_LO, a_m[7:0]);
         wr(stc_pkg::OFS_CTRL1, rnd[23:16]);
         rd(stc_pkg::OFS_CTRL1, rnd[23:16]);
      end
      // Internal clock sources, about 203 cycles of running each
      wr(stc_pkg::OFS_CMPA_LO, 8'h00);
      wr(stc_pkg::OFS_CMPA_HI, 8'h00);
      wr(stc_pkg::OFS_CTRL1, 8'h00);
      for (i = 0; i < 6; i++) begin
         wr(stc_pkg::OFS_CTRL0, 8'h08 | 8'(i << 4));
         repeat (200) @(posedge core_clk);
         wr(stc_pkg::OFS_CTRL0, 8'(i << 4));
         e = 203 / dv[i];
         rd(stc_pkg::OFS_CNT_HI, 8'h00);
         apb(1'b0, stc_pkg::OFS_CNT_LO, 8'h00, 8'(e > 3 ? e - 3 : 0), 8'(e + 3), 1'b0);
      end
      // External edges, stop, restart, pause
      wr(stc_pkg::OFS_CTRL0, 8'h68);
      pulse(5);
      cnt_is(8'h05);
      wr(stc_pkg::OFS_CTRL0, 8'h60);
      pulse(3);
      cnt_is(8'h05);
      wr(stc_pkg::OFS_CTRL0, 8'hE8);
      pulse(4);
      cnt_is(8'h00);
      wr(stc_pkg::OFS_CTRL0, 8'h68);
      pulse(2);
      cnt_is(8'h02);
      // Pause mid-count, then resume from the held value
      wr(stc_pkg::OFS_CTRL0, 8'hE8);
      pulse(2);
      cnt_is(8'h02);
      wr(stc_pkg::OFS_CTRL0, 8'h68);
      pulse(1);
      cnt_is(8'h03);
      wr(stc_pkg::OFS_CTRL0, 8'h70);
      wr(stc_pkg::OFS_CTRL0, 8'h78);
      pulse(3);
      cnt_is(8'h03);
      // Compare mode: toggle on A match, A clears
      wr(stc_pkg::OFS_CMPA_LO, 8'h03);
      wr(stc_pkg::OFS_CMPA_HI, 8'h00);
      run(8'h39);
      check(out_pin === 1'b1 && out_oe === 1'b1, "initial level");
      k = n_a;
      e = n_clr;
      pulse(3);
      check(out_pin === 1'b0 && n_a == k + 1 && n_clr == e + 1, "toggle");
      pulse(3);
      check(out_pin === 1'b1, "toggle back");
      cnt_is(8'h00);
      run(8'h29);
      k = n_a;
      pulse(3);
      check(out_pin === 1'b1 && n_a == k + 1, "same level");
      run(8'h3D);
      check(out_pin === 1'b0, "inverted start");
      pulse(3);
      check(out_pin === 1'b1, "inverted toggle");
      // Drive-low and no-change pin actions
      run(8'h19);
      pulse(3);
      check(out_pin === 1'b0, "match drives low");
      run(8'h09);
      k = n_a;
      pulse(3);
      check(out_pin === 1'b1 && n_a == k + 1, "match leaves pin");
      run(8'hC0);
      check(out_oe === 1'b0 && out_pin === 1'b0, "counter mode pin");
      // P match in 256-count steps
      wr(stc_pkg::OFS_CMPP, 8'h01);
      run(8'h00);
      k = n_p;
      pulse(258);
      check(n_p == k + 1, "P match");
      cnt_is(8'h02);
      // PWM: period and duty swap, clear source ignored
      run(8'hA9);
      pulse(260);
      check(out_pin === 1'b0, "duty over");
      cnt_is(8'h04);
      run(8'hAB);
      pulse(5);
      check(out_pin === 1'b1, "swapped duty");
      cnt_is(8'h02);
      // Forced levels and single-pulse start level
      for (i = 0; i < 4; i++) begin
         run(fc[i]);
         check(out_pin === fp[i], "forced level");
      end
      // Capture edge codes
      for (i = 0; i < 4; i++) begin
         run(8'h40 | 8'(i << 4));
         k = n_cap;
         far_u.cap_pulse();
         check(n_cap == k + cap_exp[i], "capture count");
      end
      stop_test();
   end
endmodule
